// ---- rtl/err_report_pkg.sv ----
// constants for the bridge error reporting block
`default_nettype none
package err_report_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // register indexes
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_BRIDGE_CTRL = 4'h2;
    localparam logic [3:0] REG_SEC_STATUS = 4'h3;
    localparam logic [3:0] REG_SERR_STATUS = 4'h4;
    localparam logic [3:0] REG_EVENT_DISABLE = 4'h5;
    localparam logic [3:0] REG_RETRY_LIMIT = 4'h6;
    localparam logic [3:0] REG_LOCK_STATE = 4'h7;
    // command register bits
    localparam int CMD_PERR_RESP = 6;
    localparam int CMD_SERR_EN = 8;
    // primary status bits
    localparam int STAT_SIG_SERR = 30;
    // bridge control bits
    localparam int BC_PERR_RESP = 0;
    localparam int BC_SERR_FWD = 1;
    localparam int BC_MTO_SERR_EN = 11;
    // secondary status bits
    localparam int SSTAT_RCV_SERR = 30;
    // event numbers, also bit positions in status and disable registers
    localparam int EV_PW_PARITY = 0;
    localparam int EV_PW_TABORT = 1;
    localparam int EV_PW_MABORT = 2;
    localparam int EV_PW_RETRY = 3;
    localparam int EV_DW_RETRY = 4;
    localparam int EV_DR_RETRY = 5;
    localparam int EV_MTO = 6;
    localparam int EV_SEC_SERR = 7;
    localparam int EV_N = 8;
    // retry counter
    localparam int RETRY_W = 25;
    localparam logic [24:0] RETRY_DEFAULT = 25'h100_0000;
    localparam logic [24:0] RETRY_ONE = 25'h000_0001;
    localparam logic [31:0] ZERO32 = 32'h0000_0000;
endpackage
`default_nettype wire

// ---- rtl/bridge_error_reporting.sv ----
// parity and system error reporting for a two port bus bridge
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module bridge_error_reporting (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [err_report_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [err_report_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [err_report_pkg::DATA_W-1:0] reg_rdata,
    // secondary side parity: bad data seen while write target or read initiator
    input wire logic sec_data_parity_bad,
    input wire logic sec_is_wtarget_or_rinit,
    // upstream delayed write completing on primary, primary parity error seen
    input wire logic us_dw_completion,
    input wire logic primary_parity_error_n,
    input wire logic secondary_parity_error_in_n,
    // posted write, delayed transaction and secondary system error events
    input wire logic pw_upstream,
    input wire logic pw_downstream,
    input wire logic pw_detected_as_target,
    input wire logic pw_target_abort,
    input wire logic pw_master_abort,
    input wire logic pw_retry,
    input wire logic pw_done,
    input wire logic dw_retry,
    input wire logic dw_done,
    input wire logic dr_retry,
    input wire logic dr_done,
    input wire logic delayed_master_timeout,
    input wire logic secondary_sys_error_in_n,
    // lock state per bus
    input wire logic pri_lock_set,
    input wire logic pri_lock_clr,
    input wire logic sec_lock_set,
    input wire logic sec_lock_clr,
    output logic secondary_parity_error_n,
    output logic primary_sys_error_n,
    output logic pw_discard,
    output logic dw_discard,
    output logic pri_locked,
    output logic sec_locked
);
    import err_report_pkg::*;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] cmd_q;
    logic [DATA_W-1:0] bctl_q;
    logic [EV_N-1:0] evdis_q;
    logic [EV_N-1:0] serr_stat_q;
    logic sig_serr_q;
    logic rcv_serr_q;
    logic [RETRY_W-1:0] retry_limit_q;
    logic [RETRY_W-1:0] pw_cnt_q;
    logic [RETRY_W-1:0] dw_cnt_q;
    logic [RETRY_W-1:0] dr_cnt_q;
    logic [EV_N-1:0] ev_raw;
    logic [EV_N-1:0] ev_go;
    logic serr_fire;
    logic pw_lim;
    logic dw_lim;
    logic dr_lim;

    function automatic logic [RETRY_W-1:0] next_cnt(input logic [RETRY_W-1:0] c, input logic retry,
                                                    input logic clr);
        if (clr) begin
            return '0;
        end
        if (retry) begin
            return c + RETRY_ONE;
        end
        return c;
    endfunction

    function automatic logic hits_limit(input logic [RETRY_W-1:0] c, input logic retry,
                                        input logic [RETRY_W-1:0] lim);
        return retry && (c + RETRY_ONE >= lim);
    endfunction

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    assign pw_lim = hits_limit(pw_cnt_q, pw_retry, retry_limit_q);
    assign dw_lim = hits_limit(dw_cnt_q, dw_retry, retry_limit_q);
    assign dr_lim = hits_limit(dr_cnt_q, dr_retry, retry_limit_q);

    always_comb begin
        ev_raw = '0;
        ev_raw[EV_PW_PARITY] = ((pw_upstream && !primary_parity_error_n) ||
                                (pw_downstream && !secondary_parity_error_in_n)) &&
                               !pw_detected_as_target && cmd_q[CMD_PERR_RESP] && bctl_q[BC_PERR_RESP];
        ev_raw[EV_PW_TABORT] = pw_target_abort;
        ev_raw[EV_PW_MABORT] = pw_master_abort;
        ev_raw[EV_PW_RETRY] = pw_lim;
        ev_raw[EV_DW_RETRY] = dw_lim;
        ev_raw[EV_DR_RETRY] = dr_lim;
        ev_raw[EV_MTO] = delayed_master_timeout && bctl_q[BC_MTO_SERR_EN];
        ev_raw[EV_SEC_SERR] = !secondary_sys_error_in_n && bctl_q[BC_SERR_FWD];
    end

    // master timeout has no disable bit
    always_comb begin
        ev_go = ev_raw & ~evdis_q;
        ev_go[EV_MTO] = ev_raw[EV_MTO];
    end

    assign serr_fire = (|ev_go) && cmd_q[CMD_SERR_EN];

    // ------------------------------------------------------------
    // retry counters
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pw_cnt_q <= '0;
            dw_cnt_q <= '0;
            dr_cnt_q <= '0;
        end else begin
            pw_cnt_q <= next_cnt(pw_cnt_q, pw_retry, pw_done || pw_lim);
            dw_cnt_q <= next_cnt(dw_cnt_q, dw_retry, dw_done || dw_lim);
            dr_cnt_q <= next_cnt(dr_cnt_q, dr_retry, dr_done || dr_lim);
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pw_discard <= 1'b0;
            dw_discard <= 1'b0;
        end else begin
            pw_discard <= pw_lim;
            dw_discard <= dw_lim;
        end
    end

    // ------------------------------------------------------------
    // error outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            primary_sys_error_n <= 1'b1;
        end else begin
            primary_sys_error_n <= !serr_fire;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            secondary_parity_error_n <= 1'b1;
        end else begin
            secondary_parity_error_n <= !(bctl_q[BC_PERR_RESP] &&
                ((sec_is_wtarget_or_rinit && sec_data_parity_bad) ||
                 (us_dw_completion && !primary_parity_error_n && cmd_q[CMD_PERR_RESP])));
        end
    end

    // ------------------------------------------------------------
    // lock tracking, one flag per bus
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pri_locked <= 1'b0;
        end else if (pri_lock_set) begin
            pri_locked <= 1'b1;
        end else if (pri_lock_clr) begin
            pri_locked <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sec_locked <= 1'b0;
        end else if (sec_lock_set) begin
            sec_locked <= 1'b1;
        end else if (sec_lock_clr) begin
            sec_locked <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            cmd_q <= '0;
            bctl_q <= '0;
            evdis_q <= '0;
            retry_limit_q <= RETRY_DEFAULT;
        end else if (reg_write) begin
            case (reg_addr)
                REG_CMD: cmd_q <= reg_wdata;
                REG_BRIDGE_CTRL: bctl_q <= reg_wdata;
                REG_EVENT_DISABLE: evdis_q <= reg_wdata[EV_N-1:0];
                REG_RETRY_LIMIT: retry_limit_q <= reg_wdata[RETRY_W-1:0];
                default: begin
                end
            endcase
        end
    end

    // sticky flags: write one to clear, a new event wins over the clear
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            sig_serr_q <= 1'b0;
            rcv_serr_q <= 1'b0;
            serr_stat_q <= '0;
        end else begin
            if (serr_fire) begin
                sig_serr_q <= 1'b1;
            end else if (reg_write && reg_addr == REG_STATUS && reg_wdata[STAT_SIG_SERR]) begin
                sig_serr_q <= 1'b0;
            end
            if (serr_fire && ev_go[EV_SEC_SERR]) begin
                rcv_serr_q <= 1'b1;
            end else if (reg_write && reg_addr == REG_SEC_STATUS && reg_wdata[SSTAT_RCV_SERR]) begin
                rcv_serr_q <= 1'b0;
            end
            serr_stat_q <= (reg_write && reg_addr == REG_SERR_STATUS) ?
                           ((serr_stat_q & ~reg_wdata[EV_N-1:0]) | (serr_fire ? ev_go : '0)) :
                           (serr_stat_q | (serr_fire ? ev_go : '0));
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            case (reg_addr)
                REG_CMD: reg_rdata <= cmd_q;
                REG_STATUS: reg_rdata <= ZERO32 | ({31'h0000_0000, sig_serr_q} << STAT_SIG_SERR);
                REG_BRIDGE_CTRL: reg_rdata <= bctl_q;
                REG_SEC_STATUS: reg_rdata <= ZERO32 | ({31'h0000_0000, rcv_serr_q} << SSTAT_RCV_SERR);
                REG_SERR_STATUS: reg_rdata <= {24'h00_0000, serr_stat_q};
                REG_EVENT_DISABLE: reg_rdata <= {24'h00_0000, evdis_q};
                REG_RETRY_LIMIT: reg_rdata <= {7'h00, retry_limit_q};
                REG_LOCK_STATE: reg_rdata <= {30'h0000_0000, sec_locked, pri_locked};
                default: reg_rdata <= ZERO32;
            endcase
        end else begin
            reg_rdata <= ZERO32;
        end
    end

    // ------------------------------------------------------------
    // checks: system error output
    // ------------------------------------------------------------
    a_serr_needs_enable: assert property (@(posedge mclk) disable iff (!nrst)
        !primary_sys_error_n |-> $past(cmd_q[CMD_SERR_EN])) else $error("serr without enable");

    a_serr_sets_status: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(primary_sys_error_n) |-> sig_serr_q) else $error("signaled bit not set");

    a_sec_forward: assert property (@(posedge mclk) disable iff (!nrst)
        (!secondary_sys_error_in_n && bctl_q[BC_SERR_FWD] && cmd_q[CMD_SERR_EN] && !evdis_q[EV_SEC_SERR])
        |=> !primary_sys_error_n) else $error("secondary serr not forwarded");

    a_sec_received: assert property (@(posedge mclk) disable iff (!nrst)
        (serr_fire && ev_go[EV_SEC_SERR]) |=> rcv_serr_q) else $error("received bit not set");

    a_tabort_cause: assert property (@(posedge mclk) disable iff (!nrst)
        (pw_target_abort && cmd_q[CMD_SERR_EN] && !evdis_q[EV_PW_TABORT]) |=> !primary_sys_error_n)
        else $error("target abort not reported");

    a_mabort_cause: assert property (@(posedge mclk) disable iff (!nrst)
        (pw_master_abort && cmd_q[CMD_SERR_EN] && !evdis_q[EV_PW_MABORT]) |=> !primary_sys_error_n)
        else $error("master abort not reported");

    a_mto_cause: assert property (@(posedge mclk) disable iff (!nrst)
        (delayed_master_timeout && bctl_q[BC_MTO_SERR_EN] && cmd_q[CMD_SERR_EN]) |=> !primary_sys_error_n)
        else $error("master timeout not reported");

    a_mto_gated: assert property (@(posedge mclk) disable iff (!nrst)
        (delayed_master_timeout && !bctl_q[BC_MTO_SERR_EN] && ev_go[EV_MTO-1:0] == '0 && !ev_go[EV_SEC_SERR])
        |=> primary_sys_error_n) else $error("timeout not gated");

    a_disable_masks: assert property (@(posedge mclk) disable iff (!nrst)
        (ev_raw != '0 && (ev_raw & ~evdis_q) == '0 && !ev_raw[EV_MTO]) |=> primary_sys_error_n)
        else $error("disabled event reported");

    a_status_records: assert property (@(posedge mclk) disable iff (!nrst)
        $fell(primary_sys_error_n) |-> serr_stat_q != '0) else $error("cause not recorded");

    // ------------------------------------------------------------
    // checks: parity errors
    // ------------------------------------------------------------
    a_pw_parity_up: assert property (@(posedge mclk) disable iff (!nrst)
        (pw_upstream && !primary_parity_error_n && !pw_detected_as_target && cmd_q[CMD_PERR_RESP] &&
         bctl_q[BC_PERR_RESP] && cmd_q[CMD_SERR_EN] && !evdis_q[EV_PW_PARITY]) |=> !primary_sys_error_n)
        else $error("upstream posted parity not reported");

    a_pw_parity_down: assert property (@(posedge mclk) disable iff (!nrst)
        (pw_downstream && !secondary_parity_error_in_n && !pw_detected_as_target && cmd_q[CMD_PERR_RESP] &&
         bctl_q[BC_PERR_RESP] && cmd_q[CMD_SERR_EN] && !evdis_q[EV_PW_PARITY]) |=> !primary_sys_error_n)
        else $error("downstream posted parity not reported");

    a_pw_as_target: assert property (@(posedge mclk) disable iff (!nrst)
        pw_detected_as_target |-> !ev_raw[EV_PW_PARITY]) else $error("parity seen as target reported");

    a_pw_parity_bits: assert property (@(posedge mclk) disable iff (!nrst)
        !(cmd_q[CMD_PERR_RESP] && bctl_q[BC_PERR_RESP]) |-> !ev_raw[EV_PW_PARITY])
        else $error("posted parity without response bits");

    a_sperr_resp: assert property (@(posedge mclk) disable iff (!nrst)
        !secondary_parity_error_n |-> $past(bctl_q[BC_PERR_RESP])) else $error("parity without response bit");

    a_sperr_role: assert property (@(posedge mclk) disable iff (!nrst)
        (sec_is_wtarget_or_rinit && sec_data_parity_bad && bctl_q[BC_PERR_RESP]) |=> !secondary_parity_error_n)
        else $error("secondary parity error not driven");

    a_sperr_upstream: assert property (@(posedge mclk) disable iff (!nrst)
        (us_dw_completion && !primary_parity_error_n && cmd_q[CMD_PERR_RESP] && bctl_q[BC_PERR_RESP])
        |=> !secondary_parity_error_n) else $error("upstream delayed write parity not driven");

    a_sperr_both_bits: assert property (@(posedge mclk) disable iff (!nrst)
        (!secondary_parity_error_n && !($past(sec_is_wtarget_or_rinit) && $past(sec_data_parity_bad)))
        |-> $past(cmd_q[CMD_PERR_RESP])) else $error("delayed write parity without command bit");

    // ------------------------------------------------------------
    // checks: retry limits
    // ------------------------------------------------------------
    a_pw_discard: assert property (@(posedge mclk) disable iff (!nrst)
        pw_discard |-> pw_cnt_q == '0) else $error("posted counter not cleared");

    a_pw_discard_retry: assert property (@(posedge mclk) disable iff (!nrst)
        pw_discard |-> $past(pw_retry)) else $error("posted discard without retry");

    a_dw_discard: assert property (@(posedge mclk) disable iff (!nrst)
        dw_discard |-> dw_cnt_q == '0) else $error("delayed counter not cleared");

    a_dw_discard_retry: assert property (@(posedge mclk) disable iff (!nrst)
        dw_discard |-> $past(dw_retry)) else $error("delayed discard without retry");

    a_dr_limit_cause: assert property (@(posedge mclk) disable iff (!nrst)
        (dr_lim && cmd_q[CMD_SERR_EN] && !evdis_q[EV_DR_RETRY]) |=> !primary_sys_error_n)
        else $error("read retry limit not reported");

    // ------------------------------------------------------------
    // checks: bus locks
    // ------------------------------------------------------------
    a_pri_lock_alone: assert property (@(posedge mclk) disable iff (!nrst)
        (pri_lock_set && !sec_lock_set && !sec_lock_clr) |=> (pri_locked && $stable(sec_locked)))
        else $error("primary lock disturbed secondary");

    a_sec_lock_alone: assert property (@(posedge mclk) disable iff (!nrst)
        (sec_lock_set && !pri_lock_set && !pri_lock_clr) |=> (sec_locked && $stable(pri_locked)))
        else $error("secondary lock disturbed primary");

    a_both_locks: assert property (@(posedge mclk) disable iff (!nrst)
        (pri_lock_set && sec_lock_set) |=> (pri_locked && sec_locked)) else $error("locks not held together");
endmodule
`default_nettype wire

// ---- testbench/bus_agent.sv ----
// far side bus agent that raises one cycle combinations of bus events
`timescale 1ns/10ps
`default_nettype none
module bus_agent (
    input wire logic mclk,
    output logic [21:0] ev
);
    // bits 6, 7 and 21 are active low error lines, idle high
    localparam logic [21:0] LOW_MASK = 22'h20_00c0;
    logic [21:0] act_q = 22'h00_0000;
    assign ev = act_q ^ LOW_MASK;
    // drive holds one event combination for a single cycle, then returns to idle
    task automatic drive(input logic [21:0] v);
        @(posedge mclk);
        act_q <= v;
        @(posedge mclk);
        act_q <= 22'h00_0000;
    endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
// self-checking bench for the bridge error reporting block
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import err_report_pkg::*;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [21:0] ev;
    logic sperr_n, serr_n, pw_discard, dw_discard, pri_locked, sec_locked;
    int bad_count = 0;
    int n_checks = 0;
    int evb[3] = '{EV_PW_TABORT, EV_PW_MABORT, EV_MTO};
    always #25 mclk = ~mclk;
    bus_agent agent (.mclk(mclk), .ev(ev));
    bridge_error_reporting dut (
        .mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .sec_data_parity_bad(ev[8]), .sec_is_wtarget_or_rinit(ev[9]), .us_dw_completion(ev[10]),
        .primary_parity_error_n(ev[7]), .secondary_parity_error_in_n(ev[21]),
        .pw_upstream(ev[11]), .pw_downstream(ev[12]), .pw_detected_as_target(ev[13]),
        .pw_target_abort(ev[0]), .pw_master_abort(ev[1]), .pw_retry(ev[3]), .pw_done(ev[18]),
        .dw_retry(ev[4]), .dw_done(ev[19]), .dr_retry(ev[5]), .dr_done(ev[20]),
        .delayed_master_timeout(ev[2]), .secondary_sys_error_in_n(ev[6]),
        .pri_lock_set(ev[14]), .pri_lock_clr(ev[16]), .sec_lock_set(ev[15]), .sec_lock_clr(ev[17]),
        .secondary_parity_error_n(sperr_n), .primary_sys_error_n(serr_n),
        .pw_discard(pw_discard), .dw_discard(dw_discard), .pri_locked(pri_locked), .sec_locked(sec_locked)
    );
    // ----------------------------------------
    // access and compare tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e, input string nm);
        @(posedge mclk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1;
        chk(nm, e, reg_rdata);
    endtask
    task automatic clr();
        wr(REG_STATUS, 32'hffff_ffff);
        wr(REG_SEC_STATUS, 32'hffff_ffff);
        wr(REG_SERR_STATUS, 32'hffff_ffff);
    endtask
    // drive events, check outputs the cycle after, then the error pulse ending
    task automatic ev_chk(input logic [21:0] v, input logic es, input logic ep, input logic [1:0] ed);
        agent.drive(v);
        #1;
        chk("primary_sys_error_n", {31'h0, es}, {31'h0, serr_n});
        chk("secondary_parity_error_n", {31'h0, ep}, {31'h0, sperr_n});
        chk("discard", {30'h0, ed}, {30'h0, dw_discard, pw_discard});
        @(posedge mclk);
        #1;
        chk("primary_sys_error_n end", 32'h0000_0001, {31'h0, serr_n});
        chk("secondary_parity_error_n end", 32'h0000_0001, {31'h0, sperr_n});
    endtask
    // drive lock pulses, then compare both lock flags
    task automatic lk(input logic [21:0] v, input logic [1:0] e);
        agent.drive(v);
        #1;
        chk("locks", {30'h0, e}, {30'h0, sec_locked, pri_locked});
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge mclk);
        bad_count++;
        finish_test();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        rd(REG_RETRY_LIMIT, {7'h00, RETRY_DEFAULT}, "retry limit");
        wr(4'h9, 32'hffff_ffff);
        rd(4'h9, ZERO32, "unmapped");
        ev_chk(22'h00_0001, 1'b1, 1'b1, 2'b00);
        rd(REG_SERR_STATUS, ZERO32, "serr status off");
        wr(REG_CMD, 32'h0000_0140);
        wr(REG_BRIDGE_CTRL, 32'h0000_0803);
        wr(REG_RETRY_LIMIT, 32'h0000_0004);
        rd(REG_CMD, 32'h0000_0140, "command");
        rd(REG_BRIDGE_CTRL, 32'h0000_0803, "bridge control");
        rd(REG_RETRY_LIMIT, 32'h0000_0004, "retry limit set");
        ev_chk(22'h00_0040, 1'b0, 1'b1, 2'b00);
        rd(REG_STATUS, 32'h4000_0000, "signaled serr");
        rd(REG_SEC_STATUS, 32'h4000_0000, "received serr");
        rd(REG_SERR_STATUS, 32'h0000_0080, "serr cause");
        clr();
        rd(REG_STATUS, ZERO32, "signaled serr cleared");
        rd(REG_SEC_STATUS, ZERO32, "received serr cleared");
        for (int k = 0; k < 3; k++) begin
            ev_chk(22'h00_0001 << k, 1'b0, 1'b1, 2'b00);
            rd(REG_SERR_STATUS, 32'h0000_0001 << evb[k], "serr cause");
            clr();
        end
        wr(REG_EVENT_DISABLE, 32'h0000_0042);
        rd(REG_EVENT_DISABLE, 32'h0000_0042, "event disable");
        ev_chk(22'h00_0001, 1'b1, 1'b1, 2'b00);
        ev_chk(22'h00_0004, 1'b0, 1'b1, 2'b00);
        wr(REG_BRIDGE_CTRL, 32'h0000_0003);
        ev_chk(22'h00_0004, 1'b1, 1'b1, 2'b00);
        wr(REG_EVENT_DISABLE, ZERO32);
        clr();
        for (int k = 0; k < 3; k++) begin
            for (int i = 1; i <= 4; i++) begin
                ev_chk(22'h00_0008 << k, i != 4, 1'b1, (i == 4 && k < 2) ? (2'b01 << k) : 2'b00);
            end
            rd(REG_SERR_STATUS, 32'h0000_0008 << k, "retry cause");
            clr();
            agent.drive(22'h04_0000 << k);
        end
        ev_chk(22'h00_0880, 1'b0, 1'b1, 2'b00);
        rd(REG_SERR_STATUS, 32'h0000_0001, "parity cause");
        clr();
        ev_chk(22'h20_1000, 1'b0, 1'b1, 2'b00);
        ev_chk(22'h00_2880, 1'b1, 1'b1, 2'b00);
        ev_chk(22'h00_0300, 1'b1, 1'b0, 2'b00);
        ev_chk(22'h00_0100, 1'b1, 1'b1, 2'b00);
        ev_chk(22'h00_0480, 1'b1, 1'b0, 2'b00);
        wr(REG_BRIDGE_CTRL, 32'h0000_0002);
        ev_chk(22'h00_0880, 1'b1, 1'b1, 2'b00);
        ev_chk(22'h00_0300, 1'b1, 1'b1, 2'b00);
        wr(REG_BRIDGE_CTRL, 32'h0000_0003);
        wr(REG_CMD, 32'h0000_0100);
        ev_chk(22'h00_0880, 1'b1, 1'b1, 2'b00);
        ev_chk(22'h00_0480, 1'b1, 1'b1, 2'b00);
        agent.drive(22'h00_c000);
        #1;
        chk("locks", 32'h0000_0003, {30'h0, sec_locked, pri_locked});
        agent.drive(22'h01_0000);
        #1;
        chk("locks", 32'h0000_0002, {30'h0, sec_locked, pri_locked});
        lk(22'h02_0000, 2'b00);
        lk(22'h00_4000, 2'b01);
        lk(22'h00_8000, 2'b11);
        rd(REG_LOCK_STATE, 32'h0000_0003, "lock state");
        finish_test();
    end
endmodule
`default_nettype wire
